// ### srp_top.sv
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/10ps
// Functional notes
// R1 - Four sources: pin, watchdog, power-on, brownout
// R2 - Reset starts oscillator, reinitialises flash controller
// R3 - Low pin pulse of 50 ns resets
// R4 - Registers defined, fetch from zero at release
// R5 - Brownout interrupt at selected level
// R6 - Brownout interrupt signal readable in status
// R7 - Selectable brownout level forces chip reset
// R8 - Pattern enables protection; in-application programming unrestricted
// R9 - Level one: no debug, limited programming
// R10 - Level two: no debug, erase-then-update programming
// R11 - Level three: nothing allowed, entry pin ignored
// R12 - Entry pin sampling disabled independently
// R13 - Pin low scan port, high debug
// R14 - Debug port disabled during reset
// R15 - Scan mode takes over four pins
// R16 - Tester erases, waits 250 us, scans
// R17 - Scan port gives no processor debug
// R18 - Internal oscillator clocks after every reset
// R19 - Sources ORed, async assert, sync release; only power-on asserts async, others through the register
module srp_top
  import srp_pkg::*;
#(
  parameter int          OSC_START_CYC = 16,
  parameter logic [31:0] PROT_PAT_ONE  = 32'h0000_0001,
  parameter logic [31:0] PROT_PAT_TWO  = 32'h0000_0002,
  parameter logic [31:0] PROT_PAT_THR  = 32'h0000_0003,
  parameter logic [31:0] PROT_PAT_NPIN = 32'h0000_0004
) (
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic        CE_I,
  input  wire logic        RESET_PIN_I,
  input  wire logic        WDT_RST_I,
  input  wire logic [3:0]  BOD_BELOW_I,
  input  wire logic        FLASH_READY_I,
  input  wire logic [31:0] FLASH_PROT_WORD_I,
  input  wire logic [7:0]  REG_ADDR_I,
  input  wire logic [31:0] REG_WDATA_I,
  input  wire logic        REG_WR_I,
  input  wire logic        REG_RD_I,
  output logic      [31:0] REG_RDATA_O,
  output logic             IRQ_O,
  output logic             BOD_IRQ_O,
  output logic             CHIP_RST_N_O,
  output logic             OSC_EN_O,
  output logic             FLASH_INIT_O,
  output logic             CORE_RST_N_O,
  output logic      [31:0] BOOT_PC_O,
  output logic      [1:0]  CLK_SRC_O,
  output logic             SWD_EN_O,
  output logic             SCAN_MODE_O,
  output logic      [3:0]  SCAN_PIN_OVR_O,
  output logic      [1:0]  ISP_MODE_O,
  output logic             ISP_SECTOR0_EN_O,
  output logic             ISP_PIN_EN_O,
  output logic             IAP_EN_O
);

  localparam logic [3:0] FILT_LAST = 4'(SRP_RST_FILT_CYC - 1);
  localparam logic [7:0] OSC_LAST  = 8'(OSC_START_CYC - 1);

  srp_state_t st_r;
  srp_state_t st_nxt;
  logic [31:0] boot_pc_r;

  logic       pin_low;
  logic       bod_rst;
  logic       any_src;
  logic       bod_int_now;
  logic [1:0] ev;
  logic [1:0] w1c;
  logic       wr_ctrl;
  logic       wr_mask;
  logic       run;
  logic       dbg_ok;

  // Next-state logic of the whole block
  always_comb begin
    st_nxt = st_r;

    // Two-stage synchronisers for pin and brownout comparators
    st_nxt.pin_s1 = RESET_PIN_I;
    st_nxt.pin_s2 = st_r.pin_s1;
    st_nxt.bod_s1 = BOD_BELOW_I;
    st_nxt.bod_s2 = st_r.bod_s1;

    // Low-pulse filter on the reset pin
    pin_low = ~st_r.pin_s2;
    if (pin_low) begin
      if (st_r.filt_cnt != FILT_LAST) begin
        st_nxt.filt_cnt = st_r.filt_cnt + 4'h1;
      end
    end else begin
      st_nxt.filt_cnt = 4'h0;
    end
    st_nxt.pin_rst = pin_low &
      (st_r.pin_rst | (st_r.filt_cnt == FILT_LAST)); // [R3]

    // Brownout compare against selected levels
    bod_int_now = st_r.bod_s2[st_r.ctrl.bod_int_sel]; // [R5]
    bod_rst = st_r.ctrl.bod_rst_en &
      st_r.bod_s2[st_r.ctrl.bod_rst_sel];             // [R7]
    st_nxt.bod_int = bod_int_now;

    // Any source restarts the sequence
    any_src = st_r.pin_rst | WDT_RST_I | bod_rst; // [R1] [R19]

    // Register writes
    wr_ctrl = REG_WR_I && (REG_ADDR_I == SRP_OFS_CTRL);
    wr_mask = REG_WR_I && (REG_ADDR_I == SRP_OFS_INT_MASK);
    w1c = '0;
    if (REG_WR_I && (REG_ADDR_I == SRP_OFS_INT_STAT)) begin
      w1c = REG_WDATA_I[1:0];
    end
    if (wr_ctrl) begin
      st_nxt.ctrl.bod_int_sel =
        REG_WDATA_I[SRP_CTRL_INT_SEL_LSB +: 2];
      st_nxt.ctrl.bod_rst_sel =
        REG_WDATA_I[SRP_CTRL_RST_SEL_LSB +: 2];
      st_nxt.ctrl.bod_rst_en  = REG_WDATA_I[SRP_CTRL_RST_EN_BIT];
      st_nxt.ctrl.clk_src     =
        REG_WDATA_I[SRP_CTRL_CLK_SRC_LSB +: 2];
    end
    if (wr_mask) begin
      st_nxt.int_mask = REG_WDATA_I[1:0];
    end

    // Sticky events; a new event beats a clear in the same cycle
    ev[SRP_INT_BOD_FALL] = bod_int_now & ~st_r.bod_int;
    ev[SRP_INT_BOD_RISE] = ~bod_int_now & st_r.bod_int;
    st_nxt.int_stat = (st_r.int_stat & ~w1c) | ev;

    // Reset cause, survives chip reset, cleared by one
    if (REG_WR_I && (REG_ADDR_I == SRP_OFS_CAUSE)) begin
      st_nxt.cause = st_r.cause & ~REG_WDATA_I[3:0];
    end
    if (st_r.pin_rst) begin
      st_nxt.cause[SRP_CAUSE_PIN] = 1'b1;
    end
    if (WDT_RST_I) begin
      st_nxt.cause[SRP_CAUSE_WDT] = 1'b1;
    end
    if (bod_rst) begin
      st_nxt.cause[SRP_CAUSE_BOD] = 1'b1;
    end

    // Reset sequencer
    unique case (st_r.fsm)
      SRP_ST_HOLD: begin
        st_nxt.wait_cnt = 8'h00;
        if (!any_src) begin
          st_nxt.fsm = SRP_ST_OSC;
        end
      end
      SRP_ST_OSC: begin
        st_nxt.wait_cnt = st_r.wait_cnt + 8'h01;
        if (st_r.wait_cnt == OSC_LAST) begin
          st_nxt.fsm = SRP_ST_FLASH;
        end
      end
      SRP_ST_FLASH: begin
        if (FLASH_READY_I) begin
          st_nxt.fsm = SRP_ST_LOAD;
        end
      end
      SRP_ST_LOAD: begin
        // Protection only on an exact pattern
        unique case (FLASH_PROT_WORD_I)
          PROT_PAT_ONE: st_nxt.lvl = SRP_LVL_ONE;   // [R8]
          PROT_PAT_TWO: st_nxt.lvl = SRP_LVL_TWO;   // [R8]
          PROT_PAT_THR: st_nxt.lvl = SRP_LVL_THREE; // [R8]
          default:      st_nxt.lvl = SRP_LVL_OPEN;
        endcase
        st_nxt.pin_off = (FLASH_PROT_WORD_I == PROT_PAT_NPIN); // [R12]
        st_nxt.fsm = SRP_ST_RUN;
      end
      SRP_ST_RUN: begin
      end
      default: begin
        st_nxt.fsm = SRP_ST_HOLD;
      end
    endcase
    if (any_src) begin
      st_nxt.fsm = SRP_ST_HOLD;
    end

    // Registers return to defined values while held
    if (st_nxt.fsm == SRP_ST_HOLD) begin
      st_nxt.ctrl     = '0;                 // [R4]
      st_nxt.int_stat = '0;                 // [R4]
      st_nxt.int_mask = '0;                 // [R4]
      st_nxt.lvl      = SRP_LVL_OPEN;
      st_nxt.pin_off  = 1'b0;
    end

    // Sequencer-driven outputs
    run = (st_nxt.fsm == SRP_ST_RUN);
    st_nxt.chip_rst_n = (st_nxt.fsm != SRP_ST_HOLD);
    st_nxt.osc_en     = (st_nxt.fsm != SRP_ST_HOLD);      // [R2]
    st_nxt.flash_init = (st_nxt.fsm == SRP_ST_FLASH);     // [R2]
    st_nxt.core_rst_n = run;                              // [R4] [R19]
    st_nxt.clk_src    = run ? st_nxt.ctrl.clk_src
                            : SRP_CLK_IRC;                // [R18]

    // Port selection from the pin level
    st_nxt.scan_mode = ~st_r.pin_s2;                     // [R13]
    st_nxt.scan_ovr  = {4{~st_r.pin_s2}};                // [R15]
    dbg_ok = run & st_r.pin_s2 &
      (st_nxt.lvl == SRP_LVL_OPEN);            // [R9] [R10] [R11]
    st_nxt.swd_en = dbg_ok;                    // [R13] [R14] [R17]

    // Programming permissions by level
    st_nxt.isp_mode   = st_nxt.lvl;            // [R9] [R10] [R11]
    st_nxt.sector0_en = (st_nxt.lvl == SRP_LVL_OPEN) |
                        (st_nxt.lvl == SRP_LVL_TWO);     // [R9]
    st_nxt.isp_pin_en = ~st_nxt.pin_off &
      (st_nxt.lvl != SRP_LVL_THREE);                     // [R11] [R12]
    st_nxt.iap_en     = 1'b1;                            // [R8]

    // Interrupt output
    st_nxt.irq = |(st_nxt.int_stat & st_nxt.int_mask);

    // Read data, valid the cycle after the strobe only
    st_nxt.rdata = '0;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        SRP_OFS_CTRL: begin
          st_nxt.rdata[SRP_CTRL_INT_SEL_LSB +: 2] = st_r.ctrl.bod_int_sel;
          st_nxt.rdata[SRP_CTRL_RST_SEL_LSB +: 2] = st_r.ctrl.bod_rst_sel;
          st_nxt.rdata[SRP_CTRL_RST_EN_BIT]      = st_r.ctrl.bod_rst_en;
          st_nxt.rdata[SRP_CTRL_CLK_SRC_LSB +: 2] = st_r.ctrl.clk_src;
        end
        SRP_OFS_STATUS: begin
          st_nxt.rdata[SRP_STAT_BELOW_LSB +: 4] = st_r.bod_s2;
          st_nxt.rdata[SRP_STAT_BOD_INT_BIT]    = st_r.bod_int; // [R6]
          st_nxt.rdata[SRP_STAT_SCAN_BIT]       = st_r.scan_mode;
        end
        SRP_OFS_INT_STAT: st_nxt.rdata[1:0] = st_r.int_stat;
        SRP_OFS_INT_MASK: st_nxt.rdata[1:0] = st_r.int_mask;
        SRP_OFS_CAUSE:    st_nxt.rdata[3:0] = st_r.cause;
        SRP_OFS_PROT: begin
          st_nxt.rdata[SRP_PROT_LVL_LSB +: 2] = st_r.lvl;
          st_nxt.rdata[SRP_PROT_PIN_OFF_BIT]  = st_r.pin_off;
        end
        default: st_nxt.rdata = '0;
      endcase
    end

    // Freeze everything while the clock enable is low
    if (!CE_I) begin
      st_nxt = st_r;
    end
  end

  // State register; power-on reset asserts at once
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_r          <= '0;                 // [R19]
      st_r.pin_s1   <= 1'b1;
      st_r.pin_s2   <= 1'b1;
      st_r.fsm      <= SRP_ST_HOLD;        // [R1]
      st_r.cause    <= SRP_CAUSE_RST;
      st_r.lvl      <= SRP_LVL_OPEN;
      st_r.clk_src  <= SRP_CLK_IRC;        // [R18]
      st_r.iap_en   <= 1'b1;
      boot_pc_r     <= SRP_BOOT_PC_RST;
    end else begin
      st_r      <= st_nxt;
      boot_pc_r <= SRP_BOOT_PC_RST;        // [R4]
    end
  end

  // Outputs straight from the state register
  assign REG_RDATA_O      = st_r.rdata;
  assign IRQ_O            = st_r.irq;
  assign BOD_IRQ_O        = st_r.bod_int;  // [R5]
  assign CHIP_RST_N_O     = st_r.chip_rst_n;
  assign OSC_EN_O         = st_r.osc_en;
  assign FLASH_INIT_O     = st_r.flash_init;
  assign CORE_RST_N_O     = st_r.core_rst_n;
  assign BOOT_PC_O        = boot_pc_r;
  assign CLK_SRC_O        = st_r.clk_src;
  assign SWD_EN_O         = st_r.swd_en;
  assign SCAN_MODE_O      = st_r.scan_mode;
  assign SCAN_PIN_OVR_O   = st_r.scan_ovr;
  assign ISP_MODE_O       = st_r.isp_mode;
  assign ISP_SECTOR0_EN_O = st_r.sector0_en;
  assign ISP_PIN_EN_O     = st_r.isp_pin_en;
  assign IAP_EN_O         = st_r.iap_en;

endmodule

// ### srp_pkg.sv
package srp_pkg;

  // Register byte offsets
  localparam logic [7:0] SRP_OFS_CTRL     = 8'h00;
  localparam logic [7:0] SRP_OFS_STATUS   = 8'h04;
  localparam logic [7:0] SRP_OFS_INT_STAT = 8'h08;
  localparam logic [7:0] SRP_OFS_INT_MASK = 8'h0c;
  localparam logic [7:0] SRP_OFS_CAUSE    = 8'h10;
  localparam logic [7:0] SRP_OFS_PROT     = 8'h14;

  // CTRL field positions
  localparam int SRP_CTRL_INT_SEL_LSB = 0;
  localparam int SRP_CTRL_RST_SEL_LSB = 2;
  localparam int SRP_CTRL_RST_EN_BIT  = 4;
  localparam int SRP_CTRL_CLK_SRC_LSB = 5;

  // STATUS field positions
  localparam int SRP_STAT_BELOW_LSB   = 0;
  localparam int SRP_STAT_BOD_INT_BIT = 4;
  localparam int SRP_STAT_SCAN_BIT    = 5;

  // PROT field positions
  localparam int SRP_PROT_LVL_LSB     = 0;
  localparam int SRP_PROT_PIN_OFF_BIT = 2;

  // Interrupt status bits
  localparam int SRP_INT_BOD_FALL = 0;
  localparam int SRP_INT_BOD_RISE = 1;

  // Reset cause bits
  localparam int SRP_CAUSE_POR = 0;
  localparam int SRP_CAUSE_PIN = 1;
  localparam int SRP_CAUSE_WDT = 2;
  localparam int SRP_CAUSE_BOD = 3;

  // Reset values
  localparam logic [3:0] SRP_CAUSE_RST = 4'h1;
  localparam logic [1:0] SRP_CLK_IRC   = 2'h0;
  localparam logic [31:0] SRP_BOOT_PC_RST = 32'h0000_0000;

  // Reset pin filter: shortest recognised low pulse
  localparam int SRP_CLK_PERIOD_PS  = 4000;
  localparam int SRP_RST_PULSE_NS   = 50;
  localparam int SRP_RST_FILT_CALC  =
    (SRP_RST_PULSE_NS * 1000) / SRP_CLK_PERIOD_PS;
  localparam int SRP_RST_FILT_CYC   =
    (SRP_RST_FILT_CALC < 1) ? 1 : SRP_RST_FILT_CALC;

  // Protection levels
  typedef enum logic [1:0] {
    SRP_LVL_OPEN  = 2'h0,
    SRP_LVL_ONE   = 2'h1,
    SRP_LVL_TWO   = 2'h2,
    SRP_LVL_THREE = 2'h3
  } srp_lvl_t;

  // Sequencer states
  typedef enum logic [4:0] {
    SRP_ST_HOLD  = 5'h01,
    SRP_ST_OSC   = 5'h02,
    SRP_ST_FLASH = 5'h04,
    SRP_ST_LOAD  = 5'h08,
    SRP_ST_RUN   = 5'h10
  } srp_fsm_t;

  typedef struct packed {
    logic [1:0] clk_src;
    logic       bod_rst_en;
    logic [1:0] bod_rst_sel;
    logic [1:0] bod_int_sel;
  } srp_ctrl_t;

  // State of the block except the boot vector register
  typedef struct packed {
    logic        pin_s1;
    logic        pin_s2;
    logic [3:0]  bod_s1;
    logic [3:0]  bod_s2;
    logic [3:0]  filt_cnt;
    logic        pin_rst;
    srp_fsm_t    fsm;
    logic [7:0]  wait_cnt;
    srp_ctrl_t   ctrl;
    logic [1:0]  int_stat;
    logic [1:0]  int_mask;
    logic [3:0]  cause;
    srp_lvl_t    lvl;
    logic        pin_off;
    logic        bod_int;
    logic [31:0] rdata;
    logic        chip_rst_n;
    logic        osc_en;
    logic        flash_init;
    logic        core_rst_n;
    logic        swd_en;
    logic        scan_mode;
    logic [3:0]  scan_ovr;
    logic [1:0]  isp_mode;
    logic        sector0_en;
    logic        isp_pin_en;
    logic        iap_en;
    logic        irq;
    logic [1:0]  clk_src;
  } srp_state_t;

endpackage

// ### srp_top_chk.sv
`timescale 1ns/10ps
module srp_top_chk (
  input wire logic        CLK_I,
  input wire logic        RST_N_I,
  input wire logic        RESET_PIN_I,
  input wire logic        WDT_RST_I,
  input wire logic        CHIP_RST_N_O,
  input wire logic        OSC_EN_O,
  input wire logic        FLASH_INIT_O,
  input wire logic        CORE_RST_N_O,
  input wire logic [31:0] BOOT_PC_O,
  input wire logic [1:0]  CLK_SRC_O,
  input wire logic        SWD_EN_O,
  input wire logic        SCAN_MODE_O,
  input wire logic [3:0]  SCAN_PIN_OVR_O
);
  logic [4:0] low_r;
  // Counts consecutive low samples of the reset pin
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I)
      low_r <= 5'h0;
    else if (RESET_PIN_I)
      low_r <= 5'h0;
    else if (low_r != 5'h1f)
      low_r <= low_r + 5'h1;
  end
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);
  chk_boot_vector:
    assert property (BOOT_PC_O == 32'h0) else $error("boot pc not zero");
  chk_swd_off:
    assert property (!CORE_RST_N_O |-> !SWD_EN_O) else $error("swd in reset");
  chk_scan_pins:
    assert property (SCAN_PIN_OVR_O == {4{SCAN_MODE_O}}) else $error("ovr");
  chk_scan_nodbg:
    assert property (SCAN_MODE_O |-> !SWD_EN_O) else $error("swd in scan");
  chk_osc_src:
    assert property (!CORE_RST_N_O |-> CLK_SRC_O == 2'h0) else $error("src");
  chk_osc_start:
    assert property ($rose(FLASH_INIT_O) |-> $past(OSC_EN_O, 2))
      else $error("flash init before oscillator start");
  chk_flash_first:
    assert property ($rose(CORE_RST_N_O) |-> $past(FLASH_INIT_O, 2))
      else $error("flash init skipped");
  chk_wdt_reset:
    assert property (WDT_RST_I |-> ##[1:3] !CHIP_RST_N_O) else $error("wdt");
  chk_pin_reset:
    assert property (low_r == 5'h12 |-> !CHIP_RST_N_O) else $error("pin");
endmodule
bind srp_top srp_top_chk i_srp_top_chk (.*);

// ### srp_far.sv
`timescale 1ns/10ps
module srp_far (
  input  wire logic clk_i,
  input  wire logic flash_init_i,
  output logic      pin_o,
  output logic      ready_o
);
  int dly = 3;
  int cnt = 0;
  initial pin_o = 1'b1;
  initial ready_o = 1'b0;
  // Flash controller reports ready some cycles after init starts
  always @(posedge clk_i) begin
    cnt <= flash_init_i ? cnt + 1 : 0;
    ready_o <= flash_init_i && cnt >= dly;
  end
  // Reset pin held low for n cycles, idle level high
  task automatic pulse(input int n);
    @(posedge clk_i);
    pin_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    pin_o <= 1'b1;
  endtask
  // Tester: pin high for 250 us from the call, then low for a scan
  task automatic scan(input int n);
    repeat (62500) @(posedge clk_i);
    pulse(n);
  endtask
endmodule

// ### system_reset_and_protection_tb.sv
`timescale 1ns/10ps
module system_reset_and_protection_tb;
  logic CLK_I, RST_N_I, CE_I, WDT_RST_I, REG_WR_I, REG_RD_I;
  logic RESET_PIN_I, FLASH_READY_I, IRQ_O, BOD_IRQ_O, CHIP_RST_N_O;
  logic OSC_EN_O, FLASH_INIT_O, CORE_RST_N_O, SWD_EN_O, SCAN_MODE_O;
  logic ISP_SECTOR0_EN_O, ISP_PIN_EN_O, IAP_EN_O;
  logic [1:0]  CLK_SRC_O, ISP_MODE_O;
  logic [3:0]  BOD_BELOW_I, SCAN_PIN_OVR_O;
  logic [7:0]  REG_ADDR_I;
  logic [31:0] REG_WDATA_I, FLASH_PROT_WORD_I, REG_RDATA_O, BOOT_PC_O;
  int errors, n_tests, cyc, lows;
  srp_top #(.OSC_START_CYC(4)) i_srp_top (.*);
  srp_far i_srp_far (.clk_i(CLK_I), .flash_init_i(FLASH_INIT_O),
    .pin_o(RESET_PIN_I), .ready_o(FLASH_READY_I));
  // Clock and hang limit
  initial begin
    CLK_I = 1'b0;
    forever #2 CLK_I = ~CLK_I;
  end
  always @(posedge CLK_I) begin
    cyc++;
    if (cyc == 90000) begin
      errors++;
      conclude();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Register bus cycles
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK_I);
    REG_ADDR_I <= a;
    REG_WDATA_I <= d;
    REG_WR_I <= 1'b1;
    @(posedge CLK_I);
    REG_WR_I <= 1'b0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge CLK_I);
    REG_ADDR_I <= a;
    REG_RD_I <= 1'b1;
    @(posedge CLK_I);
    REG_RD_I <= 1'b0;
    #1 chk(REG_RDATA_O, e);
  endtask
  // Waits for the core to leave reset
  task automatic run_wait();
    repeat (4) @(posedge CLK_I);
    for (int i = 0; i < 300 && CORE_RST_N_O !== 1'b1; i++)
      @(negedge CLK_I);
    #1 chk(CORE_RST_N_O, 1);
  endtask
  task automatic wdt();
    @(posedge CLK_I);
    WDT_RST_I <= 1'b1;
    @(posedge CLK_I);
    WDT_RST_I <= 1'b0;
    run_wait();
  endtask
  // Counts low cycles of the chip reset over n cycles
  task automatic watch(input int n);
    lows = 0;
    repeat (n) @(negedge CLK_I) lows += int'(!CHIP_RST_N_O);
  endtask
  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {RST_N_I, WDT_RST_I, REG_WR_I, REG_RD_I, BOD_BELOW_I} = '0;
    {REG_ADDR_I, REG_WDATA_I} = '0;
    CE_I = 1'b1;
    FLASH_PROT_WORD_I = 32'h55;
    repeat (8) @(posedge CLK_I);
    RST_N_I <= 1'b1;
    run_wait();
    chk(SWD_EN_O, 1);
    rdc(8'h10, 32'h1);
    rdc(8'h40, 32'h0);
    wr(8'h00, 32'h40);
    rdc(8'h00, 32'h40);
    chk(CLK_SRC_O, 2);
    wdt();
    chk(CLK_SRC_O, 0);
    rdc(8'h10, 32'h5);
    wr(8'h10, 32'hf);
    // Every protection level, then the entry-pin-off word, slow flash
    i_srp_far.dly = 40;
    for (int lv = 0; lv < 5; lv++) begin
      FLASH_PROT_WORD_I <= (lv == 0) ? 32'h55 : 32'(lv);
      wdt();
      chk(ISP_MODE_O, lv % 4);
      chk(SWD_EN_O, lv % 4 == 0);
      chk(ISP_SECTOR0_EN_O, lv % 4 == 0 || lv == 2);
      chk(ISP_PIN_EN_O, lv < 3);
      chk(IAP_EN_O, 1);
      rdc(8'h14, 32'(lv));
    end
    wr(8'h10, 32'hf);
    // Short and 50 ns pin pulses
    for (int n = 8; n < 14; n += 5) begin
      fork
        i_srp_far.pulse(n);
        watch(40);
      join
      chk(lows > 0, n > 12);
      run_wait();
    end
    rdc(8'h10, 32'h2);
    // Brownout interrupt, masked and unmasked
    for (int m = 1; m >= 0; m--) begin
      wr(8'h00, 32'h1);
      wr(8'h0c, 32'(m));
      BOD_BELOW_I <= 4'h2;
      repeat (6) @(posedge CLK_I);
      #1 chk(BOD_IRQ_O, 1);
      chk(IRQ_O, m);
      rdc(8'h04, 32'h12);
      rdc(8'h08, 32'h1);
      BOD_BELOW_I <= 4'h0;
      repeat (6) @(posedge CLK_I);
      wr(8'h08, 32'h3);
      rdc(8'h08, 32'h0);
      chk(IRQ_O, 0);
    end
    // Brownout reset at each selectable level
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, 32'h10 | 32'(s << 2));
      BOD_BELOW_I <= 4'h1 << s;
      watch(10);
      chk(lows > 0, 1);
      @(posedge CLK_I);
      BOD_BELOW_I <= 4'h0;
      run_wait();
    end
    rdc(8'h10, 32'ha);
    // Boundary scan entry and exit
    fork
      i_srp_far.scan(30);
      begin
        repeat (62528) @(negedge CLK_I);
        chk(CHIP_RST_N_O, 0);
        chk(SCAN_MODE_O, 1);
        chk(SCAN_PIN_OVR_O, 4'hf);
        chk(SWD_EN_O, 0);
      end
    join
    run_wait();
    chk(SCAN_MODE_O, 0);
    chk(SWD_EN_O, 1);
    conclude();
  end
endmodule
